// ===== afs_regs.vh
// Purpose: constants for the axis fault supervisor
// Assumes: APB, 32-bit words, byte addresses
// Notes:   offsets, field positions, reset values and codes
`ifndef AFS_REGS_VH
`define AFS_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AFS_OFF_CTRL      12'h000
`define AFS_OFF_STATUS    12'h004
`define AFS_OFF_FAULT     12'h008
`define AFS_OFF_IRQ_STAT  12'h00C
`define AFS_OFF_IRQ_CLR   12'h010
`define AFS_OFF_IRQ_EN    12'h014
`define AFS_OFF_DIST      12'h018
`define AFS_OFF_BRAKE     12'h01C
`define AFS_OFF_CLEAR     12'h020

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define AFS_CTRL_HOST_RDY 0
`define AFS_CTRL_RETRY_EN 1
`define AFS_CTRL_SG1_DEC  2
`define AFS_CTRL_SG3_DEC  3
`define AFS_CTRL_MPG_MODE 4
`define AFS_CTRL_POL_LSB  8
`define AFS_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define AFS_ST_MOD_RDY    0
`define AFS_ST_BUSY       1
`define AFS_ST_ERR        2
`define AFS_ST_WARN       3
`define AFS_ST_OPR_DONE   4
`define AFS_ST_OP_LSB     8

// ----------------------------------------------------------------
// interrupt bits (status, clear and enable share this layout)
// ----------------------------------------------------------------
`define AFS_IRQ_FAULT     0
`define AFS_IRQ_REFUSE    1
`define AFS_IRQ_STOP      2

// ----------------------------------------------------------------
// fault codes
// ----------------------------------------------------------------
`define AFS_E_NONE        16'h0000
`define AFS_E_LOWER_LIM   16'd105
`define AFS_E_STOP_AT_GO  16'd106
`define AFS_E_RDY_BUSY    16'd107
`define AFS_E_AT_ORIGIN   16'd201
`define AFS_E_DOG_TIMING  16'd203
`define AFS_E_ZERO_TIMING 16'd204
`define AFS_E_DWELL       16'd205
`define AFS_E_COUNT_DIST  16'd206

// ----------------------------------------------------------------
// origin-return kinds on start_kind
// ----------------------------------------------------------------
`define AFS_K_NORMAL      3'h0
`define AFS_K_DOG         3'h1
`define AFS_K_STOPPER1    3'h2
`define AFS_K_STOPPER2    3'h3
`define AFS_K_COUNT1      3'h4
`define AFS_K_COUNT2      3'h5

// ----------------------------------------------------------------
// operation states shown in status
// ----------------------------------------------------------------
`define AFS_OP_STANDBY    2'h0
`define AFS_OP_RUN        2'h1
`define AFS_OP_STOPPING   2'h2
`define AFS_OP_ERROR      2'h3

`endif

// ===== afs_axis_fault_supervisor.v
// Purpose: fault supervision of one positioning axis
// Assumes: motion engine reports phase and stop completion
// Notes:   registers over APB, zero wait states
`timescale 1ns/100ps
`include "afs_regs.vh"

module afs_axis_fault_supervisor #(
  parameter DIST_W = 32
) (
  input  wire              ref_clk,
  input  wire              reset,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              lower_travel_limit_in,
  input  wire              upper_travel_limit_in,
  input  wire              stop_in,
  input  wire              dog_in,
  input  wire              zero_in,
  input  wire              start_req,
  input  wire [2:0]        start_kind,
  input  wire              creep_slowing,
  input  wire              dwell_expired,
  input  wire              stop_done,
  input  wire              opr_done_set,
  input  wire              warn_set,
  output reg               run_ff,
  output reg               halt_ff,
  output reg               halt_decel_ff,
  output reg               module_ready_flag_ff,
  output reg               irq_ff
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  // ----------------------------------------------------------------
  reg [4:0] s1_ff, s2_ff, s3_ff, pin_ff;
  wire [4:0] pins_raw = {zero_in, dog_in, stop_in,
                         upper_travel_limit_in, lower_travel_limit_in};
  always @(posedge ref_clk) begin
    if (reset) begin
      s1_ff  <= 5'h00;
      s2_ff  <= 5'h00;
      s3_ff  <= 5'h00;
      pin_ff <= 5'h00;
    end else begin
      s1_ff <= pins_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0]       ctrl_ff;
  reg [15:0]       fault_code_ff;
  reg [15:0]       warn_code_ff;
  reg              err_ff;
  reg              warn_ff;
  reg              opr_done_ff;
  reg              host_rdy_d_ff;
  reg [2:0]        kind_ff;
  reg [2:0]        irq_stat_ff;
  reg [2:0]        irq_en_ff;
  reg [DIST_W-1:0] dist_ff;
  reg [DIST_W-1:0] brake_ff;

  // polarity select inverts pins so 1 means active
  wire [4:0] act = pin_ff ^ ctrl_ff[`AFS_CTRL_POL_LSB+4:`AFS_CTRL_POL_LSB];
  wire lower_ok = act[0];
  wire stop_on  = act[2];
  wire dog_on   = act[3];
  wire zero_on  = act[4];
  reg  dog_d_ff, zero_d_ff, lower_d_ff;

  wire host_rdy = ctrl_ff[`AFS_CTRL_HOST_RDY];
  wire retry_en = ctrl_ff[`AFS_CTRL_RETRY_EN];
  wire mpg_mode = ctrl_ff[`AFS_CTRL_MPG_MODE];

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a <= `AFS_OFF_CLEAR) && (a[1:0] == 2'b00);
    end
  endfunction

  wire wr_clear = wr_acc && (paddr == `AFS_OFF_CLEAR) && pwdata[0];
  wire wr_iclr  = wr_acc && (paddr == `AFS_OFF_IRQ_CLR);

  // ----------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------
  reg        refuse;
  reg        stop_g1;
  reg        stop_g3;
  reg        rdy_fault;
  reg [15:0] nxt_code;
  wire is_count = (start_kind == `AFS_K_COUNT1) ||
                  (start_kind == `AFS_K_COUNT2);
  always @* begin
    refuse    = 1'b0;
    stop_g1   = 1'b0;
    stop_g3   = 1'b0;
    rdy_fault = 1'b0;
    nxt_code  = `AFS_E_NONE;
    if (start_req && !run_ff && !halt_ff) begin
      if (!lower_ok) begin
        refuse = 1'b1;
        nxt_code = `AFS_E_LOWER_LIM;
      end else if (stop_on) begin
        refuse = 1'b1;
        nxt_code = `AFS_E_STOP_AT_GO;
      end else if (start_kind == `AFS_K_DOG && !retry_en && opr_done_ff) begin
        refuse = 1'b1;
        nxt_code = `AFS_E_AT_ORIGIN;
      end else if (is_count && (dist_ff < brake_ff)) begin
        refuse = 1'b1;
        nxt_code = `AFS_E_COUNT_DIST;
      end
    end else if (run_ff && !halt_ff) begin
      if (lower_d_ff && !lower_ok) begin
        stop_g1 = 1'b1;
        nxt_code = `AFS_E_LOWER_LIM;
      end else if (kind_ff == `AFS_K_DOG && creep_slowing &&
                   dog_d_ff && !dog_on) begin
        stop_g3 = 1'b1;
        nxt_code = `AFS_E_DOG_TIMING;
      end else if (kind_ff == `AFS_K_STOPPER2 && creep_slowing &&
                   zero_d_ff && !zero_on) begin
        stop_g3 = 1'b1;
        nxt_code = `AFS_E_ZERO_TIMING;
      end else if (kind_ff == `AFS_K_STOPPER1 && creep_slowing &&
                   dwell_expired) begin
        stop_g3 = 1'b1;
        nxt_code = `AFS_E_DWELL;
      end
    end
    if (host_rdy && !host_rdy_d_ff && (run_ff || halt_ff)) begin
      rdy_fault = 1'b1;
      if (nxt_code == `AFS_E_NONE)
        nxt_code = `AFS_E_RDY_BUSY;
    end
  end

  wire new_fault = refuse | stop_g1 | stop_g3 | rdy_fault;
  wire go = start_req && !run_ff && !halt_ff && !refuse && !err_ff;

  // ----------------------------------------------------------------
  // motion control, fault and status state
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      run_ff        <= 1'b0;
      halt_ff       <= 1'b0;
      halt_decel_ff <= 1'b0;
      kind_ff       <= `AFS_K_NORMAL;
      err_ff        <= 1'b0;
      warn_ff       <= 1'b0;
      fault_code_ff <= `AFS_E_NONE;
      warn_code_ff  <= `AFS_E_NONE;
      opr_done_ff   <= 1'b0;
      host_rdy_d_ff <= 1'b0;
      dog_d_ff      <= 1'b0;
      zero_d_ff     <= 1'b0;
      lower_d_ff    <= 1'b0;
      module_ready_flag_ff <= 1'b0;
    end else begin
      host_rdy_d_ff <= host_rdy;
      dog_d_ff      <= dog_on;
      zero_d_ff     <= zero_on;
      lower_d_ff    <= lower_ok;
      if (go) begin
        run_ff  <= 1'b1;
        kind_ff <= start_kind;
      end
      if (stop_g1 || stop_g3) begin
        run_ff  <= 1'b0;
        halt_ff <= 1'b1;
        // decel only in manual pulse mode
        halt_decel_ff <= mpg_mode &&
          (stop_g1 ? ctrl_ff[`AFS_CTRL_SG1_DEC] : ctrl_ff[`AFS_CTRL_SG3_DEC]);
      end else if (halt_ff && stop_done) begin
        halt_ff       <= 1'b0;
        halt_decel_ff <= 1'b0;
      end else if (run_ff && stop_done) begin
        run_ff <= 1'b0;
      end
      // ready follows host unless a busy fault holds it low
      if (!host_rdy)
        module_ready_flag_ff <= 1'b0;
      else if (rdy_fault)
        module_ready_flag_ff <= 1'b0;
      else if (!host_rdy_d_ff)
        module_ready_flag_ff <= 1'b1;
      if (opr_done_set)
        opr_done_ff <= 1'b1;
      else if (go && start_kind != `AFS_K_NORMAL)
        opr_done_ff <= 1'b0;
      // clear error state; new fault wins
      if (wr_clear) begin
        err_ff        <= 1'b0;
        warn_ff       <= 1'b0;
        fault_code_ff <= `AFS_E_NONE;
        warn_code_ff  <= `AFS_E_NONE;
      end
      if (warn_set)
        warn_ff <= 1'b1;
      if (new_fault) begin
        err_ff        <= 1'b1;
        fault_code_ff <= nxt_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky status, write-one clear, enable mask
  // ----------------------------------------------------------------
  wire [2:0] ev = {stop_g1 | stop_g3, refuse, new_fault};
  always @(posedge ref_clk) begin
    if (reset) begin
      irq_stat_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      irq_stat_ff <= (irq_stat_ff & ~(wr_iclr ? pwdata[2:0] : 3'h0)) | ev;
      irq_ff      <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // apb slave: writes, reads, zero wait, error on unmapped
  // ----------------------------------------------------------------
  wire [1:0] op_state = err_ff  ? `AFS_OP_ERROR :
                        halt_ff ? `AFS_OP_STOPPING :
                        run_ff  ? `AFS_OP_RUN : `AFS_OP_STANDBY;
  always @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff   <= `AFS_CTRL_RESET;
      irq_en_ff <= 3'h0;
      dist_ff   <= {DIST_W{1'b0}};
      brake_ff  <= {DIST_W{1'b0}};
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (wr_acc) begin
        case (paddr)
          `AFS_OFF_CTRL:   ctrl_ff   <= pwdata;
          `AFS_OFF_IRQ_EN: irq_en_ff <= pwdata[2:0];
          `AFS_OFF_DIST:   dist_ff   <= pwdata[DIST_W-1:0];
          `AFS_OFF_BRAKE:  brake_ff  <= pwdata[DIST_W-1:0];
          default: ;
        endcase
      end
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `AFS_OFF_CTRL:     prdata <= ctrl_ff;
          `AFS_OFF_STATUS:   prdata <= {22'h0, op_state, 3'h0, opr_done_ff,
                                        warn_ff, err_ff,
                                        run_ff | halt_ff,
                                        module_ready_flag_ff};
          `AFS_OFF_FAULT:    prdata <= {warn_code_ff, fault_code_ff};
          `AFS_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_ff};
          `AFS_OFF_IRQ_EN:   prdata <= {29'h0, irq_en_ff};
          `AFS_OFF_DIST:     prdata <= dist_ff;
          `AFS_OFF_BRAKE:    prdata <= brake_ff;
          default:           prdata <= 32'h0000_0000;
        endcase
      end else if (!rd_acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // afs_axis_fault_supervisor

// ===== afs_axis_fault_supervisor_asserts.sv
// Purpose: port-level checks of the axis fault supervisor
// Assumes: single clock domain, synchronous active-high reset
// Notes:   sees top-level ports only; bound from the bench top
`timescale 1ns/100ps
`include "afs_regs.vh"
module afs_fault_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        start_req,
  input wire logic        stop_done,
  input wire logic        run_ff,
  input wire logic        halt_ff,
  input wire logic        module_ready_flag_ff
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // write to the control word completing this cycle
  wire ctl_wr = psel && penable && pready && pwrite &&
                paddr == `AFS_OFF_CTRL;
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_unmapped_err: assert property (pready |-> pslverr ==
    (paddr > 12'h020 || paddr[1:0] != 2'h0))
    else $error("slave error does not match address map");
  a_halt_from_run: assert property ($rose(halt_ff) |->
    $past(run_ff) && !run_ff)
    else $error("fault stop without a moving axis");
  a_halt_holds: assert property (halt_ff && !stop_done |=> halt_ff)
    else $error("fault stop dropped before stop done");
  a_run_excl: assert property (!(run_ff && halt_ff))
    else $error("moving and halting at once");
  a_run_cause: assert property ($rose(run_ff) |-> $past(start_req))
    else $error("motion began without a start request");
  a_busy_ready: assert property (ctl_wr && pwdata[0] &&
    !module_ready_flag_ff && (run_ff || halt_ff) ##1 (run_ff || halt_ff)
    |-> ##1 !module_ready_flag_ff [*2])
    else $error("module ready rose while busy");
  a_ready_drop: assert property (ctl_wr && !pwdata[0] |-> ##2
    !module_ready_flag_ff)
    else $error("module ready stayed after host ready fell");
  c_halt: cover property ($rose(halt_ff));
  c_slverr: cover property (pready && pslverr);
  c_ready: cover property ($rose(module_ready_flag_ff));
endmodule // afs_fault_checker

// ===== afs_field_model.sv
// Purpose: switches and drive seen by the axis fault supervisor
// Assumes: polarity bits zero, so raw level 1 means switch ON
// Notes:   levels follow the bench's commands with no delay
`timescale 1ns/100ps
module afs_field_model (
  input  wire logic lower_on,
  input  wire logic stop_on,
  input  wire logic dog_on,
  input  wire logic zero_on,
  output wire logic lower_travel_limit_in,
  output wire logic upper_travel_limit_in,
  output wire logic stop_in,
  output wire logic dog_in,
  output wire logic zero_in
);
  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  // drive ready tied
  // a drive without ready output is wired always on; no pin here
  // upper limit held
  assign upper_travel_limit_in = 1'b1;  // no upper switch fitted
  // switch contacts as commanded
  assign lower_travel_limit_in = lower_on;
  assign stop_in               = stop_on;
  assign dog_in                = dog_on;
  assign zero_in               = zero_on;
endmodule // afs_field_model

// ===== test_axis_fault_supervisor.sv
// Purpose: self-checking bench of the axis fault supervisor
// Assumes: polarity bits zero outside t_reset; pins settle within 8 edges
// Notes:   one task per scenario; APB driven on rising edges
`timescale 1ns/100ps
`include "afs_regs.vh"
module test_axis_fault_supervisor;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err, lim_lo, stp, dog, zer, start_req, creep_slowing;
  logic        dwell_expired, stop_done, opr_done_set, warn_set;
  logic [2:0]  start_kind;
  logic        run_ff, halt_ff, halt_decel_ff, module_ready_flag_ff, irq_ff;
  logic        lower_travel_limit_in, upper_travel_limit_in, stop_in;
  logic        dog_in, zero_in;
  integer      miscompares = 0;
  integer      checked = 0;
  integer      i;
  afs_field_model i_field (.lower_on(lim_lo), .stop_on(stp), .dog_on(dog),
    .zero_on(zer), .lower_travel_limit_in, .upper_travel_limit_in,
    .stop_in, .dog_in, .zero_in);
  afs_axis_fault_supervisor i_dut (.ref_clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .lower_travel_limit_in, .upper_travel_limit_in, .stop_in, .dog_in,
    .zero_in, .start_req, .start_kind, .creep_slowing, .dwell_expired,
    .stop_done, .opr_done_set, .warn_set, .run_ff, .halt_ff,
    .halt_decel_ff, .module_ready_flag_ff, .irq_ff);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // idle edge first, so no signal is assigned twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    tick(1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      tick(1);
    end
    if (n == 16) begin
      miscompares++;
      $display("[ERR] %0t pready got %h exp %h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdx(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task go(input logic [2:0] k);
    tick(1);
    start_kind <= k;
    start_req <= 1'b1;
    tick(1);
    start_req <= 1'b0;
    tick(2);
  endtask
  task done;
    stop_done <= 1'b1;
    tick(1);
    stop_done <= 1'b0;
    tick(1);
  endtask
  task clr;
    wr(`AFS_OFF_CLEAR, 32'h1);
    tick(1);
  endtask
  task refuse(input logic [2:0] k, input logic [15:0] code);
    go(k);
    chk(run_ff, 1'b0);
    rdx(`AFS_OFF_FAULT, {16'h0, code});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    rdx(`AFS_OFF_CTRL, `AFS_CTRL_RESET);
    rdx(`AFS_OFF_STATUS, 32'h0);
    rdx(`AFS_OFF_FAULT, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    chk(err, 1'b1);
    wr(`AFS_OFF_DIST, 32'h0000_1234);
    rdx(`AFS_OFF_DIST, 32'h0000_1234);
  endtask
  task t_lower;
    wr(`AFS_OFF_IRQ_EN, 32'h7);
    wr(`AFS_OFF_CTRL, 32'h14);  // group 1 decel, manual pulse mode
    go(`AFS_K_NORMAL);
    chk(run_ff, 1'b1);
    lim_lo <= 1'b0;
    tick(8);
    chk({run_ff, halt_ff, halt_decel_ff, irq_ff}, 4'h7);
    rdx(`AFS_OFF_FAULT, 32'd105);
    rdx(`AFS_OFF_IRQ_STAT, 32'h5);
    done;
    warn_set <= 1'b1;
    tick(1);
    warn_set <= 1'b0;
    rdx(`AFS_OFF_STATUS, 32'h30C);
    wr(`AFS_OFF_IRQ_EN, 32'h0);
    tick(2);
    chk(irq_ff, 1'b0);
    wr(`AFS_OFF_IRQ_CLR, 32'h7);
    wr(`AFS_OFF_IRQ_EN, 32'h7);
    tick(2);
    chk(irq_ff, 1'b0);
    clr;
    rdx(`AFS_OFF_FAULT, 32'h0);
    rdx(`AFS_OFF_STATUS, 32'h0);
    lim_lo <= 1'b1;
    tick(8);
  endtask
  task t_refuse;
    stp <= 1'b1;
    tick(8);
    refuse(`AFS_K_NORMAL, 16'd106);
    lim_lo <= 1'b0;
    tick(8);
    refuse(`AFS_K_NORMAL, 16'd105);
    rdx(`AFS_OFF_IRQ_STAT, 32'h3);
    lim_lo <= 1'b1;
    stp <= 1'b0;
    tick(8);
    clr;
    wr(`AFS_OFF_DIST, 32'd10);
    wr(`AFS_OFF_BRAKE, 32'd11);
    refuse(`AFS_K_COUNT1, 16'd206);
    clr;
    refuse(`AFS_K_COUNT2, 16'd206);
    clr;
    wr(`AFS_OFF_BRAKE, 32'd10);
    go(`AFS_K_COUNT1);
    chk(run_ff, 1'b1);
    done;
    opr_done_set <= 1'b1;
    tick(1);
    opr_done_set <= 1'b0;
    // origin-return-complete flag shows in status bit 4
    rdx(`AFS_OFF_STATUS, 32'h10);
    wr(`AFS_OFF_CTRL, 32'h0);
    refuse(`AFS_K_DOG, 16'd201);
    clr;
    wr(`AFS_OFF_CTRL, 32'h2);
    go(`AFS_K_DOG);
    chk(run_ff, 1'b1);
    done;
  endtask
  task t_opr;
    for (i = 0; i < 3; i++) begin
      wr(`AFS_OFF_CTRL, (i == 0) ? 32'h1A : 32'h0A);
      dog <= 1'b1;
      zer <= 1'b1;
      tick(8);
      go((i == 0) ? `AFS_K_DOG : (i == 1) ? `AFS_K_STOPPER2 : `AFS_K_STOPPER1);
      creep_slowing <= 1'b1;
      dog <= (i != 0);
      zer <= (i != 1);
      dwell_expired <= (i == 2);
      tick(8);
      chk({run_ff, halt_ff, halt_decel_ff}, {2'b01, i == 0});
      rdx(`AFS_OFF_FAULT, 32'd203 + i);
      creep_slowing <= 1'b0;
      dwell_expired <= 1'b0;
      done;
      clr;
    end
  endtask
  task t_ready;
    wr(`AFS_OFF_CTRL, 32'h0);
    go(`AFS_K_NORMAL);
    wr(`AFS_OFF_CTRL, 32'h1);
    tick(3);
    chk(module_ready_flag_ff, 1'b0);
    rdx(`AFS_OFF_FAULT, 32'd107);
    done;
    clr;
    wr(`AFS_OFF_CTRL, 32'h0);
    wr(`AFS_OFF_CTRL, 32'h1);
    tick(2);
    chk(module_ready_flag_ff, 1'b1);
  endtask
  // mid-run reset while moving, then a polarity-inverted stop input
  task t_reset;
    go(`AFS_K_NORMAL);
    chk({run_ff, module_ready_flag_ff}, 2'b11);
    reset <= 1'b1;
    tick(2);
    chk({run_ff, halt_ff, halt_decel_ff, module_ready_flag_ff, irq_ff,
         pready, pslverr}, 7'h00);
    reset <= 1'b0;
    tick(6);
    rdx(`AFS_OFF_CTRL, `AFS_CTRL_RESET);
    rdx(`AFS_OFF_STATUS, 32'h0);
    rdx(`AFS_OFF_IRQ_STAT, 32'h0);
    // stop input made active by its polarity bit
    wr(`AFS_OFF_CTRL, 32'h400);
    refuse(`AFS_K_NORMAL, 16'd106);
    wr(`AFS_OFF_CTRL, 32'h0);
    clr;
  endtask
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task results;
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, stp, dog, zer, start_req} = 7'h0;
    {creep_slowing, dwell_expired, stop_done, opr_done_set} = 4'h0;
    warn_set = 1'b0;
    lim_lo = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    start_kind = 3'h0;
    tick(3);
    reset <= 1'b0;
    tick(6);
    t_regs;
    t_lower;
    t_refuse;
    t_opr;
    t_ready;
    t_reset;
    results;
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #400000;
    miscompares++;
    results;
  end
endmodule // test_axis_fault_supervisor

bind afs_axis_fault_supervisor afs_fault_checker i_chk (.ref_clk, .reset,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .start_req,
  .stop_done, .run_ff, .halt_ff, .module_ready_flag_ff);
